// [logic/cao_map.svh]
`ifndef CAO_MAP_SVH
`define CAO_MAP_SVH
`define CAO_BIT_RAM_BASE 8'h20
`define CAO_UPPER_BASE 8'h80
`define CAO_SFR_BIT_LOW_MASK 8'h07
`define CAO_NOMINAL_CLKS 4'h4
`define CAO_WAIT_W 3
`define CAO_OP_INC_A 8'h04
`define CAO_OP_INC_DIR 8'h05
`define CAO_OP_INC_IND 8'h06
`define CAO_OP_INC_REG 8'h08
`define CAO_OP_DEC_A 8'h14
`define CAO_OP_DEC_DIR 8'h15
`define CAO_OP_DEC_IND 8'h16
`define CAO_OP_DEC_REG 8'h18
`define CAO_OP_ADD 8'h20
`define CAO_OP_ADD_WITH_CARRY 8'h30
`define CAO_OP_ORL 8'h40
`define CAO_OP_ANL 8'h50
`define CAO_OP_XRL 8'h60
`define CAO_OP_SUBTRACT_WITH_BORROW 8'h90
`define CAO_OP_SHORT_RELATIVE_JUMP 8'h80
`define CAO_OP_FAR_JUMP 8'h02
`define CAO_OP_FAR_CALL 8'h12
`define CAO_OP_CODE_TABLE_READ_PC 8'h83
`define CAO_OP_CODE_TABLE_READ_DP 8'h93
`define CAO_OP_INC_DP 8'hA3
`define CAO_OP_SWAP 8'hC4
`define CAO_OP_XTRN_IND_RD 8'hE2
`define CAO_OP_XTRN_IND_WR 8'hF2
`define CAO_OP_CLR_BIT 8'hC2
`define CAO_OP_SET_BIT 8'hD2
`define CAO_LOW5_PAGE 5'h01
`define CAO_LOW5_CALL 5'h11
`define CAO_FORM_DIR_A 4'h2
`define CAO_FORM_DIR_IMM 4'h3
`define CAO_FORM_IMM 4'h4
`define CAO_FORM_DIR 4'h5
`define CAO_FORM_IND 4'h6
`define CAO_FORM_IND1 4'h7
`endif

// [logic/cao_pkg.sv]
package cao_pkg;
	typedef enum logic [2:0] {
		CAO_FETCH = 3'b000,
		CAO_OPND1 = 3'b001,
		CAO_OPND2 = 3'b011,
		CAO_EXEC = 3'b010,
		CAO_EXEC2 = 3'b110
	} cao_state_e;
endpackage

// [logic/cao_cycle_timer.sv]
`timescale 1ns/1ps
`include "cao_map.svh"
// Paces machine cycles from wait states and the clock divider setting.
module cao_cycle_timer (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [2:0] core_clock_divider_ctl_i,
	input wire logic [2:0] bus_wait_state_ctl_i,
	input wire logic stretch_i,
	output logic cycle_end_o
);
	logic [10:0] cnt_reg;
	logic [10:0] len;
	assign len = (11'(`CAO_NOMINAL_CLKS) + 11'(bus_wait_state_ctl_i)) << core_clock_divider_ctl_i; // RULE_07
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cnt_reg <= 11'h000;
		end else if (stretch_i) begin
			cnt_reg <= cnt_reg; // RULE_08
		end else if (cnt_reg >= len - 11'h001) begin
			cnt_reg <= 11'h000;
		end else begin
			cnt_reg <= cnt_reg + 11'h001;
		end
	end
	assign cycle_end_o = !stretch_i && (cnt_reg >= len - 11'h001); // RULE_08
endmodule // cao_cycle_timer

// [logic/cao_core.sv]
`timescale 1ns/1ps
`include "cao_map.svh"
// Notes on behaviour
// RULE_01: External accesses with an 8-bit pointer-register address are unsupported.
// RULE_02: Code-table read fetches program byte at accumulator plus pointer into accumulator.
// RULE_03: Short jump adds signed second byte to the instruction pointer.
// RULE_04: Page jump keeps upper five address bits, takes eleven from the instruction.
// RULE_05: Far jump and call use the two following bytes as target.
// RULE_06: Bit set and clear alter one bit in 20h-2Fh or aligned registers.
// RULE_07: Nominal machine cycle length follows wait states and clock divider.
// RULE_08: A machine cycle stretches only on prefetch stall or branch miss.
// RULE_09: Add, add with carry, subtract with borrow take one cycle.
// RULE_10: Subtract with borrow removes operand and carry from the accumulator.
// RULE_11: Increment and decrement take one cycle; direct form is two bytes.
// RULE_12: Data pointer increment is one byte and two machine cycles.
// RULE_13: AND, OR and XOR into the accumulator take one cycle.
// RULE_14: Logic result into a direct byte is two bytes, one cycle.
// RULE_15: Logic of immediate into a direct byte is three bytes, two cycles.
// RULE_16: Nibble exchange swaps accumulator halves in one byte, one cycle.
// RULE_17: Indirect accesses in the upper range reach upper RAM, never registers.
// RULE_18: Register forms pick a working register from opcode bits two to zero.
// RULE_19: Bit addresses below 80h map onto bytes 20h-2Fh, above onto registers.
module cao_core #(
	parameter int ADDR_W = 16
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [2:0] core_clock_divider_ctl_i,
	input wire logic [2:0] bus_wait_state_ctl_i,
	input wire logic prefetch_queue_stall_i,
	input wire logic branch_target_cache_miss_i,
	input wire logic [7:0] code_data_i,
	input wire logic [7:0] data_rd_i,
	output logic [ADDR_W-1:0] code_addr_o,
	output logic [7:0] data_addr_o,
	output logic data_sfr_sel_o,
	output logic data_wr_o,
	output logic [7:0] data_wr_data_o,
	output logic [7:0] accumulator_o,
	output logic [ADDR_W-1:0] instruction_pointer_o,
	output logic [ADDR_W-1:0] data_pointer_16_o,
	output logic carry_o,
	output logic illegal_op_o,
	output logic [2:0] cycles_o,
	output logic [1:0] length_o,
	output logic instr_done_o
);
	cao_pkg::cao_state_e state_reg;
	logic [7:0] op_reg;
	logic [7:0] b1_reg;
	logic [7:0] b2_reg;
	logic [7:0] accumulator_reg;
	logic carry_reg;
	logic [ADDR_W-1:0] ip_reg;
	logic [ADDR_W-1:0] dp_reg;
	logic [7:0] wreg_reg [8];
	logic [7:0] daddr_reg;
	logic dsfr_reg;
	logic dwr_reg;
	logic [7:0] dwd_reg;
	logic ill_reg;
	logic done_reg;
	logic [2:0] cyc_reg;
	logic [1:0] len_reg;
	logic [ADDR_W-1:0] caddr_reg;
	logic cycle_end;
	logic [1:0] need_len;
	logic [2:0] need_cyc;
	logic [3:0] form;
	logic [7:0] opnd;
	logic [8:0] alu;
	logic [7:0] logic_res;
	logic is_alu;
	logic is_logic;
	logic [2:0] rsel;
	logic [7:0] bit_byte;
	logic bit_sfr;
	logic acc_form;
	logic is_ind;
	logic is_bit_op;
	cao_cycle_timer u_timer (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.core_clock_divider_ctl_i(core_clock_divider_ctl_i), // RULE_07
		.bus_wait_state_ctl_i(bus_wait_state_ctl_i),
		.stretch_i(prefetch_queue_stall_i | branch_target_cache_miss_i), // RULE_08
		.cycle_end_o(cycle_end)
	);
	assign form = op_reg[3:0];
	assign rsel = op_reg[2:0]; // RULE_18
	// Accumulator-target forms take a register, indirect, direct or immediate source.
	assign acc_form = op_reg[3] || (form >= `CAO_FORM_IMM);
	assign is_ind = (form == `CAO_FORM_IND) || (form == `CAO_FORM_IND1); // RULE_17
	assign is_bit_op = (op_reg == `CAO_OP_CLR_BIT) || (op_reg == `CAO_OP_SET_BIT);
	assign is_alu = (op_reg[7:4] == `CAO_OP_ADD >> 4) || (op_reg[7:4] == `CAO_OP_ADD_WITH_CARRY >> 4)
		|| (op_reg[7:4] == `CAO_OP_SUBTRACT_WITH_BORROW >> 4);
	assign is_logic = (op_reg[7:4] == `CAO_OP_ORL >> 4) || (op_reg[7:4] == `CAO_OP_ANL >> 4)
		|| (op_reg[7:4] == `CAO_OP_XRL >> 4);
	// Bit address decode into a byte address and its space.
	assign bit_sfr = b1_reg[7]; // RULE_19
	assign bit_byte = bit_sfr ? (b1_reg & ~`CAO_SFR_BIT_LOW_MASK) : (`CAO_BIT_RAM_BASE + {4'h0, b1_reg[6:3]}); // RULE_06
	// Instruction length and machine-cycle count per opcode.
	always_comb begin
		need_len = 2'h1;
		need_cyc = 3'h1;
		if (is_alu || is_logic) begin
			if (op_reg[3]) begin
				need_len = 2'h1; // RULE_18
			end else if (is_ind) begin
				need_len = 2'h1;
			end else if (form == `CAO_FORM_IMM || form == `CAO_FORM_DIR) begin
				need_len = 2'h2; // RULE_09
			end else if (is_logic && form == `CAO_FORM_DIR_A) begin
				need_len = 2'h2; // RULE_14
			end else if (is_logic && form == `CAO_FORM_DIR_IMM) begin
				need_len = 2'h3; // RULE_15
				need_cyc = 3'h2;
			end
		end
		case (op_reg)
			`CAO_OP_INC_DIR, `CAO_OP_DEC_DIR: need_len = 2'h2; // RULE_11
			`CAO_OP_INC_DP, `CAO_OP_CODE_TABLE_READ_PC, `CAO_OP_CODE_TABLE_READ_DP: need_cyc = 3'h2; // RULE_12
			`CAO_OP_SHORT_RELATIVE_JUMP, `CAO_OP_CLR_BIT, `CAO_OP_SET_BIT: need_len = 2'h2;
			`CAO_OP_FAR_JUMP, `CAO_OP_FAR_CALL: begin
				need_len = 2'h3;
				need_cyc = 3'h2;
			end
			default: begin
				if (op_reg[4:0] == `CAO_LOW5_PAGE || op_reg[4:0] == `CAO_LOW5_CALL) begin
					need_len = 2'h2;
					need_cyc = 3'h2;
				end
			end
		endcase
	end
	// Source operand: working register, indirect, direct or immediate.
	always_comb begin
		opnd = data_rd_i;
		if (op_reg[3]) begin
			opnd = wreg_reg[rsel]; // RULE_18
		end else if (form == `CAO_FORM_IMM) begin
			opnd = b1_reg;
		end
	end
	always_comb begin
		alu = {1'b0, accumulator_reg} + {1'b0, opnd};
		if (op_reg[7:4] == `CAO_OP_ADD_WITH_CARRY >> 4) begin
			alu = {1'b0, accumulator_reg} + {1'b0, opnd} + {8'h00, carry_reg}; // RULE_09
		end else if (op_reg[7:4] == `CAO_OP_SUBTRACT_WITH_BORROW >> 4) begin
			alu = {1'b0, accumulator_reg} - {1'b0, opnd} - {8'h00, carry_reg}; // RULE_10
		end
	end
	always_comb begin
		logic_res = accumulator_reg | opnd;
		if (op_reg[7:4] == `CAO_OP_ANL >> 4) begin
			logic_res = accumulator_reg & opnd;
		end else if (op_reg[7:4] == `CAO_OP_XRL >> 4) begin
			logic_res = accumulator_reg ^ opnd; // RULE_13
		end
	end
	// Sequencer: fetch opcode and operand bytes, then execute.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_reg <= cao_pkg::CAO_FETCH;
		end else if (cycle_end) begin
			case (state_reg)
				cao_pkg::CAO_FETCH: state_reg <= cao_pkg::CAO_OPND1;
				cao_pkg::CAO_OPND1: state_reg <= (need_len == 2'h3) ? cao_pkg::CAO_OPND2 : cao_pkg::CAO_EXEC;
				cao_pkg::CAO_OPND2: state_reg <= cao_pkg::CAO_EXEC;
				cao_pkg::CAO_EXEC: state_reg <= (need_cyc == 3'h2) ? cao_pkg::CAO_EXEC2 : cao_pkg::CAO_FETCH;
				cao_pkg::CAO_EXEC2: state_reg <= cao_pkg::CAO_FETCH;
				default: state_reg <= cao_pkg::CAO_FETCH;
			endcase
		end
	end
	// Byte capture and code address walk.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			op_reg <= 8'h00;
			b1_reg <= 8'h00;
			b2_reg <= 8'h00;
			caddr_reg <= '0;
		end else if (cycle_end) begin
			case (state_reg)
				cao_pkg::CAO_FETCH: begin
					op_reg <= code_data_i;
					caddr_reg <= ip_reg + ADDR_W'(1);
				end
				cao_pkg::CAO_OPND1: begin
					b1_reg <= code_data_i;
					caddr_reg <= ip_reg + ADDR_W'(2);
				end
				cao_pkg::CAO_OPND2: b2_reg <= code_data_i;
				cao_pkg::CAO_EXEC: begin
					if (op_reg == `CAO_OP_CODE_TABLE_READ_DP) begin
						caddr_reg <= dp_reg + ADDR_W'(accumulator_reg); // RULE_02
					end else if (op_reg == `CAO_OP_CODE_TABLE_READ_PC) begin
						caddr_reg <= ip_reg + ADDR_W'(1) + ADDR_W'(accumulator_reg); // RULE_02
					end
				end
				default: caddr_reg <= ip_reg;
			endcase
		end else if (state_reg == cao_pkg::CAO_FETCH) begin
			caddr_reg <= ip_reg;
		end
	end
	// Instruction pointer update at the end of each instruction.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ip_reg <= '0;
		end else if (cycle_end && ((state_reg == cao_pkg::CAO_EXEC && need_cyc == 3'h1)
				|| state_reg == cao_pkg::CAO_EXEC2)) begin
			if (op_reg == `CAO_OP_SHORT_RELATIVE_JUMP) begin
				ip_reg <= ip_reg + ADDR_W'(2) + ADDR_W'(signed'(b1_reg)); // RULE_03
			end else if (op_reg == `CAO_OP_FAR_JUMP || op_reg == `CAO_OP_FAR_CALL) begin
				ip_reg <= {b1_reg, b2_reg}; // RULE_05
			end else if (op_reg[4:0] == `CAO_LOW5_PAGE || op_reg[4:0] == `CAO_LOW5_CALL) begin
				ip_reg <= {ip_reg[15:11] + ((ip_reg[10:0] + 11'h002) < 11'h002 ? 5'h01 : 5'h00),
					op_reg[7:5], b1_reg}; // RULE_04
			end else begin
				ip_reg <= ip_reg + ADDR_W'(need_len);
			end
		end
	end
	// Accumulator, carry, data pointer and working registers.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			accumulator_reg <= 8'h00;
			carry_reg <= 1'b0;
			dp_reg <= '0;
		end else if (cycle_end && state_reg == cao_pkg::CAO_EXEC) begin
			if (is_alu && acc_form) begin
				accumulator_reg <= alu[7:0]; // RULE_09
				carry_reg <= alu[8];
			end else if (is_logic && acc_form) begin
				accumulator_reg <= logic_res; // RULE_13
			end else if (op_reg == `CAO_OP_INC_A) begin
				accumulator_reg <= accumulator_reg + 8'h01; // RULE_11
			end else if (op_reg == `CAO_OP_DEC_A) begin
				accumulator_reg <= accumulator_reg - 8'h01; // RULE_11
			end else if (op_reg == `CAO_OP_SWAP) begin
				accumulator_reg <= {accumulator_reg[3:0], accumulator_reg[7:4]}; // RULE_16
			end else if (op_reg == `CAO_OP_INC_DP) begin
				dp_reg <= dp_reg + ADDR_W'(1); // RULE_12
			end
		end else if (cycle_end && state_reg == cao_pkg::CAO_EXEC2) begin
			if (op_reg == `CAO_OP_CODE_TABLE_READ_PC || op_reg == `CAO_OP_CODE_TABLE_READ_DP) begin
				accumulator_reg <= code_data_i; // RULE_02
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < 8; i++) begin
				wreg_reg[i] <= 8'h00;
			end
		end else if (cycle_end && state_reg == cao_pkg::CAO_EXEC && op_reg[3]) begin
			if (op_reg[7:4] == `CAO_OP_INC_REG >> 4) begin
				wreg_reg[rsel] <= wreg_reg[rsel] + 8'h01; // RULE_11
			end else if (op_reg[7:4] == `CAO_OP_DEC_REG >> 4) begin
				wreg_reg[rsel] <= wreg_reg[rsel] - 8'h01; // RULE_11
			end
		end
	end
	// Data space address and write strobe.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			daddr_reg <= 8'h00;
			dsfr_reg <= 1'b0;
			dwr_reg <= 1'b0;
			dwd_reg <= 8'h00;
		end else begin
			dwr_reg <= 1'b0;
			if (state_reg == cao_pkg::CAO_EXEC || state_reg == cao_pkg::CAO_EXEC2) begin
				if (is_ind) begin
					daddr_reg <= wreg_reg[{2'b00, op_reg[0]}];
					dsfr_reg <= 1'b0; // RULE_17
				end else if (is_bit_op) begin
					daddr_reg <= bit_byte;
					dsfr_reg <= bit_sfr; // RULE_19
				end else begin
					daddr_reg <= b1_reg;
					dsfr_reg <= b1_reg >= `CAO_UPPER_BASE;
				end
			end
			if (cycle_end && state_reg == cao_pkg::CAO_EXEC) begin
				if (is_bit_op) begin
					dwr_reg <= 1'b1;
					dwd_reg <= op_reg == `CAO_OP_SET_BIT ? (data_rd_i | (8'h01 << b1_reg[2:0]))
						: (data_rd_i & ~(8'h01 << b1_reg[2:0])); // RULE_06
				end else if (op_reg == `CAO_OP_INC_DIR || op_reg == `CAO_OP_INC_IND) begin
					dwr_reg <= 1'b1;
					dwd_reg <= data_rd_i + 8'h01; // RULE_11
				end else if (op_reg == `CAO_OP_DEC_DIR || op_reg == `CAO_OP_DEC_IND) begin
					dwr_reg <= 1'b1;
					dwd_reg <= data_rd_i - 8'h01; // RULE_11
				end else if (is_logic && form == `CAO_FORM_DIR_A) begin
					dwr_reg <= 1'b1;
					dwd_reg <= data_rd_i & accumulator_reg; // RULE_14
					if (op_reg[7:4] == `CAO_OP_ORL >> 4) dwd_reg <= data_rd_i | accumulator_reg;
					if (op_reg[7:4] == `CAO_OP_XRL >> 4) dwd_reg <= data_rd_i ^ accumulator_reg;
				end
			end else if (cycle_end && state_reg == cao_pkg::CAO_EXEC2 && is_logic && form == `CAO_FORM_DIR_IMM) begin
				dwr_reg <= 1'b1;
				dwd_reg <= data_rd_i & b2_reg; // RULE_15
				if (op_reg[7:4] == `CAO_OP_ORL >> 4) dwd_reg <= data_rd_i | b2_reg;
				if (op_reg[7:4] == `CAO_OP_XRL >> 4) dwd_reg <= data_rd_i ^ b2_reg;
			end
		end
	end
	// Status: completion pulse, length, cycle count, unsupported op flag.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			done_reg <= 1'b0;
			ill_reg <= 1'b0;
			cyc_reg <= 3'h0;
			len_reg <= 2'h0;
		end else begin
			done_reg <= cycle_end && ((state_reg == cao_pkg::CAO_EXEC && need_cyc == 3'h1)
				|| state_reg == cao_pkg::CAO_EXEC2);
			if (cycle_end && state_reg == cao_pkg::CAO_EXEC) begin
				cyc_reg <= need_cyc;
				len_reg <= need_len;
				ill_reg <= (op_reg[7:1] == `CAO_OP_XTRN_IND_RD >> 1)
					|| (op_reg[7:1] == `CAO_OP_XTRN_IND_WR >> 1); // RULE_01
			end
		end
	end
	assign code_addr_o = caddr_reg;
	assign data_addr_o = daddr_reg;
	assign data_sfr_sel_o = dsfr_reg;
	assign data_wr_o = dwr_reg;
	assign data_wr_data_o = dwd_reg;
	assign accumulator_o = accumulator_reg;
	assign instruction_pointer_o = ip_reg;
	assign data_pointer_16_o = dp_reg;
	assign carry_o = carry_reg;
	assign illegal_op_o = ill_reg;
	assign cycles_o = cyc_reg;
	assign length_o = len_reg;
	assign instr_done_o = done_reg;
endmodule // cao_core

// [bench/cao_mem_model.sv]
`timescale 1ns/1ps
// Program memory and internal data space on the far side of the core.
module cao_mem_model (
	input wire logic clk_i,
	input wire logic [15:0] code_addr_i,
	output logic [7:0] code_data_o,
	input wire logic [7:0] data_addr_i,
	input wire logic data_sfr_sel_i,
	input wire logic data_wr_i,
	input wire logic [7:0] data_wr_data_i,
	output logic [7:0] data_rd_o
);
	logic [7:0] rom [0:65535];
	logic [7:0] dmem [0:511];
	assign code_data_o = rom[code_addr_i];
	assign data_rd_o = dmem[{data_sfr_sel_i, data_addr_i}];
	always @(posedge clk_i) begin
		if (data_wr_i) begin
			dmem[{data_sfr_sel_i, data_addr_i}] <= data_wr_data_i;
		end
	end
endmodule // cao_mem_model

// [bench/cao_core_chk.sv]
`timescale 1ns/1ps
module cao_core_chk #(
	parameter int ADDR_W = 16
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic prefetch_queue_stall_i,
	input wire logic branch_target_cache_miss_i,
	input wire logic [ADDR_W-1:0] code_addr_o,
	input wire logic data_wr_o,
	input wire logic [7:0] accumulator_o,
	input wire logic [ADDR_W-1:0] data_pointer_16_o,
	input wire logic illegal_op_o,
	input wire logic [2:0] cycles_o,
	input wire logic [1:0] length_o,
	input wire logic instr_done_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	sequence s_stalled;
		prefetch_queue_stall_i [*3];
	endsequence
	sequence s_missed;
		branch_target_cache_miss_i [*3];
	endsequence
	ext_ptr_noop_a: assert property (instr_done_o && illegal_op_o |-> accumulator_o == $past(accumulator_o, 2))
		else $error("pointer move changed the accumulator");
	done_gap_a: assert property (instr_done_o |=> !instr_done_o [*3])
		else $error("instructions closer than one machine cycle");
	stall_hold_a: assert property (s_stalled |-> !instr_done_o && $stable(code_addr_o))
		else $error("core advanced during queue stall");
	miss_hold_a: assert property (s_missed |-> !instr_done_o && $stable(code_addr_o))
		else $error("core advanced during cache miss");
	data_pointer_16_step_a: assert property ($changed(data_pointer_16_o) |-> data_pointer_16_o == $past(data_pointer_16_o) + 1'b1)
		else $error("data pointer moved by other than one");
	acc_commit_a: assert property ($changed(accumulator_o) |-> instr_done_o)
		else $error("accumulator changed outside instruction end");
	status_len_a: assert property (instr_done_o |-> length_o != 2'h0 && cycles_o inside {3'h1, 3'h2, 3'h4})
		else $error("bad length or cycle count");
	wr_pulse_a: assert property (data_wr_o |=> !data_wr_o)
		else $error("data write longer than one clock");
	ill_no_write_a: assert property (instr_done_o && illegal_op_o |-> !data_wr_o)
		else $error("unsupported pointer move wrote data");
endmodule // cao_core_chk

bind cao_core cao_core_chk #(.ADDR_W(ADDR_W)) chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
	.prefetch_queue_stall_i(prefetch_queue_stall_i), .branch_target_cache_miss_i(branch_target_cache_miss_i),
	.code_addr_o(code_addr_o), .data_wr_o(data_wr_o), .accumulator_o(accumulator_o),
	.data_pointer_16_o(data_pointer_16_o), .illegal_op_o(illegal_op_o), .cycles_o(cycles_o),
	.length_o(length_o), .instr_done_o(instr_done_o));

// [bench/core_addressing_and_alu_ops_test.sv]
`timescale 1ns/1ps
module core_addressing_and_alu_ops_test;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [2:0] div = 3'h0;
	logic [2:0] wst = 3'h0;
	logic stall = 1'b0;
	logic miss = 1'b0;
	logic [7:0] code_data, data_rd, data_addr, wr_data, acc;
	logic [15:0] code_addr, ip, data_pointer_16;
	logic sfr_sel, wr, carry, illegal, done;
	logic [2:0] cycles;
	logic [1:0] length;
	int n_mismatch = 0;
	int cmp_count = 0;
	int ticks = 0;
	always #50 clk_i = ~clk_i;
	cao_core uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .core_clock_divider_ctl_i(div),
		.bus_wait_state_ctl_i(wst), .prefetch_queue_stall_i(stall), .branch_target_cache_miss_i(miss),
		.code_data_i(code_data), .data_rd_i(data_rd), .code_addr_o(code_addr), .data_addr_o(data_addr),
		.data_sfr_sel_o(sfr_sel), .data_wr_o(wr), .data_wr_data_o(wr_data), .accumulator_o(acc),
		.instruction_pointer_o(ip), .data_pointer_16_o(data_pointer_16), .carry_o(carry), .illegal_op_o(illegal),
		.cycles_o(cycles), .length_o(length), .instr_done_o(done));
	cao_mem_model mem (.clk_i(clk_i), .code_addr_i(code_addr), .code_data_o(code_data),
		.data_addr_i(data_addr), .data_sfr_sel_i(sfr_sel), .data_wr_i(wr), .data_wr_data_i(wr_data),
		.data_rd_o(data_rd));
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		ticks <= ticks + 1;
		if (ticks == 50000) begin
			n_mismatch++;
			close_out();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic boot(input logic [7:0] fill, input logic [7:0] prog [$]);
		for (int i = 0; i < 65536; i++) mem.rom[i] = fill;
		foreach (prog[i]) mem.rom[i] = prog[i];
		@(negedge clk_i);
		sys_rst_i = 1'b1;
		repeat (6) @(negedge clk_i);
		sys_rst_i = 1'b0;
	endtask
	task automatic step();
		int n = 0;
		@(negedge clk_i);
		while (done !== 1'b1 && n < 2000) begin
			@(negedge clk_i);
			n++;
		end
		if (n >= 2000) begin
			n_mismatch++;
			close_out();
		end
	endtask
	task automatic t_alu();
		logic [7:0] acc_t [6] = '{8'h01, 8'h80, 8'hFF, 8'h00, 8'hA5, 8'h5A};
		// Expected {carry, length, cycles} after each instruction.
		logic [5:0] st_t [6] = '{6'h09, 6'h11, 6'h31, 6'h31, 6'h31, 6'h29};
		boot(8'h00, '{8'h04, 8'h24, 8'h7F, 8'h94, 8'h81, 8'h34, 8'h00, 8'h64, 8'hA5, 8'hC4});
		for (int i = 0; i < 6; i++) begin
			step();
			chk(acc, acc_t[i]);
			chk({carry, length, cycles}, st_t[i]);
		end
	endtask
	task automatic t_jump();
		boot(8'h00, '{8'h02, 8'h17, 8'hFE});
		mem.rom[16'h17FE] = 8'hA1;
		mem.rom[16'h17FF] = 8'h00;
		mem.rom[16'h1D00] = 8'h80;
		mem.rom[16'h1D01] = 8'hFE;
		step();
		chk(ip, 16'h17FE);
		step();
		chk(ip, 16'h1D00);
		step();
		chk(ip, 16'h1D00);
	endtask
	task automatic t_table();
		boot(8'h00, '{8'hA3, 8'h04, 8'h93, 8'h83});
		mem.rom[16'h0097] = 8'h3C;
		step();
		chk(data_pointer_16, 16'h0001);
		chk({length, cycles}, 5'h0A);
		step();
		step();
		chk(acc, 8'h93);
		step();
		chk(acc, 8'h3C);
	endtask
	task automatic t_data();
		boot(8'h00, '{8'h43, 8'h30, 8'hF0, 8'hD2, 8'h08, 8'hC2, 8'h83, 8'hE2});
		mem.dmem[9'h030] = 8'h0F;
		mem.dmem[9'h021] = 8'h00;
		mem.dmem[9'h180] = 8'hFF;
		step();
		@(negedge clk_i);
		chk(mem.dmem[9'h030], 8'hFF);
		chk({length, cycles}, 5'h1A);
		step();
		@(negedge clk_i);
		chk(mem.dmem[9'h021], 8'h01);
		step();
		@(negedge clk_i);
		chk(mem.dmem[9'h180], 8'hF7);
		step();
		chk({illegal, acc}, 9'h100);
	endtask
	task automatic t_indirect();
		boot(8'h00, '{8'h18, 8'h06, 8'h28, 8'h62, 8'h30, 8'h15, 8'h31});
		mem.dmem[9'h0FF] = 8'h41;
		mem.dmem[9'h1FF] = 8'h77;
		mem.dmem[9'h030] = 8'h0F;
		mem.dmem[9'h031] = 8'h10;
		step();
		chk({length, cycles}, 5'h09);
		step();
		@(negedge clk_i);
		chk(mem.dmem[9'h0FF], 8'h42);
		chk(mem.dmem[9'h1FF], 8'h77);
		step();
		chk(acc, 8'hFF);
		step();
		@(negedge clk_i);
		chk(mem.dmem[9'h030], 8'hF0);
		chk({length, cycles}, 5'h11);
		step();
		@(negedge clk_i);
		chk(mem.dmem[9'h031], 8'h0F);
		chk({length, cycles}, 5'h11);
	endtask
	task automatic t_cycle();
		int g0, g1, t;
		int k = 0;
		logic [7:0] a0;
		boot(8'h04, '{8'h04});
		step();
		t = ticks;
		step();
		g0 = ticks - t;
		div = 3'h1;
		wst = 3'h1;
		boot(8'h04, '{8'h04});
		step();
		t = ticks;
		step();
		g1 = ticks - t;
		chk(16'(g1 * 4), 16'(g0 * 10));
		a0 = acc;
		stall = 1'b1;
		repeat (40) @(negedge clk_i) if (done === 1'b1) k++;
		stall = 1'b0;
		miss = 1'b1;
		repeat (40) @(negedge clk_i) if (done === 1'b1) k++;
		miss = 1'b0;
		chk(16'(k), 16'h0000);
		chk({8'h00, acc}, {8'h00, a0});
		step();
		chk({8'h00, acc}, {8'h00, a0 + 8'h01});
		div = 3'h0;
		wst = 3'h0;
	endtask
	initial begin
		t_alu();
		t_jump();
		t_table();
		t_data();
		t_indirect();
		t_cycle();
		close_out();
	end
endmodule // core_addressing_and_alu_ops_test
